/* src/wake_sniff_rate_config.sv */
// Summary of operation
// - wake-rate register, eight bits, reset zero
// - wake code read through power-mode setting
// - wake codes map to per-mode rate tables
// - code fifteen valid only after unlock
// - sniff register: standby rate, sniff rate
// - sniff codes map to per-mode tables
// - sniff column uses separate power field
// - standby 001, continuous wake 101, no sniff
module wake_sniff_rate_config
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	input  wire logic [7:0]  power_mode_reg,
	input  wire logic [2:0]  operating_mode_field,
	output logic      [7:0]  reg_rd_data,
	output logic      [15:0] wake_rate_dhz,
	output logic             wake_rate_ok,
	output logic      [15:0] sniff_rate_dhz,
	output logic             sniff_rate_ok,
	output logic      [15:0] standby_rate_dhz,
	output logic      [15:0] active_rate_dhz,
	output logic             sniff_active,
	output logic             rate15_unlocked
);

	typedef struct packed {
		logic [7:0]  wake_reg;
		logic [7:0]  sniff_reg;
		logic [7:0]  rd_data;
		logic [15:0] wake_dhz;
		logic        wake_ok;
		logic [15:0] sniff_dhz;
		logic        sniff_ok;
		logic [15:0] stby_dhz;
		logic [15:0] active_dhz;
		logic        sniff_on;
		logic        unl;
	} cfg_regs_t;

	cfg_regs_t r;
	cfg_regs_t next_r;

	logic        unlocked;
	logic [2:0]  wake_pm;
	logic [2:0]  sniff_pm;
	logic [16:0] wake_lu;
	logic [16:0] sniff_lu;
	logic [15:0] stby_lu;

	////////////////////////////////////////////////////////////////////////
	// rate tables, tenths of a hertz; msb of the wake and sniff results marks a supported code

	function automatic logic [16:0] wake_lookup(input logic [2:0] pm, input logic [3:0] code,
		input logic unl);
		logic [16:0] v;
		v = 17'h0_0000;
		case (pm)
			rate_cfg_pkg::pm_ultra_low_power:
				case (code)
					4'h6: v = {1'b1, 16'h00FA};
					4'h7: v = {1'b1, 16'h01F4};
					4'h8: v = {1'b1, 16'h03E8};
					4'h9: v = {1'b1, 16'h076C};
					4'hA: v = {1'b1, 16'h0ED8};
					4'hB: v = {1'b1, 16'h1D4C};
					4'hC: v = {1'b1, 16'h2AF8};
					4'hF: v = {unl, 16'h32C8};
					default: v = 17'h0_0000;
				endcase
			rate_cfg_pkg::pm_low_power:
				case (code)
					4'h5: v = {1'b1, 16'h008C};
					4'h6: v = {1'b1, 16'h0118};
					4'h7: v = {1'b1, 16'h021C};
					4'h8: v = {1'b1, 16'h041A};
					4'h9: v = {1'b1, 16'h0834};
					4'hA: v = {1'b1, 16'h0FA0};
					4'hB: v = {1'b1, 16'h1770};
					4'hF: v = {unl, 16'h1D4C};
					default: v = 17'h0_0000;
				endcase
			rate_cfg_pkg::pm_precision:
				case (code)
					4'h5: v = {1'b1, 16'h008C};
					4'h6: v = {1'b1, 16'h0118};
					4'h7: v = {1'b1, 16'h0226};
					4'h8: v = {1'b1, 16'h0320};
					4'hF: v = {unl, 16'h03E8};
					default: v = 17'h0_0000;
				endcase
			default: v = 17'h0_0000;
		endcase
		// locked code fifteen reports no rate at all
		if (!v[16])
			v = 17'h0_0000;
		return v;
	endfunction : wake_lookup

	function automatic logic [16:0] sniff_lookup(input logic [2:0] pm, input logic [3:0] code);
		logic [16:0] v;
		v = 17'h0_0000;
		case (pm)
			rate_cfg_pkg::pm_ultra_low_power:
				case (code)
					4'h0, 4'h4: v = {1'b1, 16'h003C};
					4'h1: v = {1'b1, 16'h0004};
					4'h2: v = {1'b1, 16'h0008};
					4'h3: v = {1'b1, 16'h000F};
					4'h5: v = {1'b1, 16'h0082};
					4'h6: v = {1'b1, 16'h00FA};
					4'h7: v = {1'b1, 16'h01F4};
					4'h8: v = {1'b1, 16'h03E8};
					4'h9: v = {1'b1, 16'h076C};
					4'hA: v = {1'b1, 16'h0ED8};
					4'hB: v = {1'b1, 16'h1D4C};
					4'hC: v = {1'b1, 16'h2AF8};
					default: v = 17'h0_0000;
				endcase
			rate_cfg_pkg::pm_low_power:
				case (code)
					4'h0, 4'h4: v = {1'b1, 16'h0046};
					4'h1: v = {1'b1, 16'h0004};
					4'h2: v = {1'b1, 16'h0008};
					4'h3: v = {1'b1, 16'h000F};
					4'h5: v = {1'b1, 16'h008C};
					4'h6: v = {1'b1, 16'h0118};
					4'h7: v = {1'b1, 16'h021C};
					4'h8: v = {1'b1, 16'h041A};
					4'h9: v = {1'b1, 16'h0834};
					4'hA: v = {1'b1, 16'h0FA0};
					4'hB: v = {1'b1, 16'h1770};
					default: v = 17'h0_0000;
				endcase
			rate_cfg_pkg::pm_precision:
				case (code)
					4'h0, 4'h4: v = {1'b1, 16'h0046};
					4'h1: v = {1'b1, 16'h0002};
					4'h2: v = {1'b1, 16'h0004};
					4'h3: v = {1'b1, 16'h0009};
					4'h5: v = {1'b1, 16'h008C};
					4'h6: v = {1'b1, 16'h0118};
					4'h7: v = {1'b1, 16'h0226};
					4'h8: v = {1'b1, 16'h0320};
					default: v = 17'h0_0000;
				endcase
			default: v = 17'h0_0000;
		endcase
		return v;
	endfunction : sniff_lookup

	function automatic logic [15:0] standby_lookup(input logic [2:0] pm, input logic [2:0] code);
		logic [15:0] v;
		v = 16'h0000;
		case (pm)
			rate_cfg_pkg::pm_ultra_low_power:
				case (code)
					3'h0: v = 16'h000A;
					3'h1: v = 16'h001E;
					3'h2: v = 16'h0032;
					3'h3: v = 16'h0064;
					3'h4: v = 16'h00E6;
					3'h5: v = 16'h01C2;
					3'h6: v = 16'h0384;
					default: v = 16'h0708;
				endcase
			rate_cfg_pkg::pm_low_power:
				case (code)
					3'h0: v = 16'h0005;
					3'h1: v = 16'h000A;
					3'h2: v = 16'h001E;
					3'h3: v = 16'h003C;
					3'h4: v = 16'h0078;
					3'h5: v = 16'h00F0;
					3'h6: v = 16'h01E0;
					default: v = 16'h03E8;
				endcase
			rate_cfg_pkg::pm_precision:
				case (code)
					3'h0: v = 16'h0001;
					3'h1: v = 16'h0002;
					3'h2: v = 16'h0004;
					3'h3: v = 16'h0008;
					3'h4: v = 16'h000F;
					3'h5: v = 16'h001E;
					3'h6: v = 16'h0032;
					default: v = 16'h0064;
				endcase
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : standby_lookup

	////////////////////////////////////////////////////////////////////////

	rate15_unlock u_unlock
	(
		.clk             (clk),
		.reset_n         (reset_n),
		.wr_en           (reg_wr_en),
		.addr            (reg_addr),
		.wr_data         (reg_wr_data),
		.wake_power_mode (wake_pm),
		.unlocked        (unlocked)
	);

	assign wake_pm  = power_mode_reg[rate_cfg_pkg::wake_pm_lsb +: 3];
	assign sniff_pm = power_mode_reg[rate_cfg_pkg::sniff_pm_lsb +: 3];

	// tables follow the stored registers and the results are registered again, so a write shows two cycles later
	assign wake_lu  = wake_lookup(wake_pm, r.wake_reg[rate_cfg_pkg::wake_code_lsb +: 4],
		unlocked);
	assign sniff_lu = sniff_lookup(sniff_pm, r.sniff_reg[rate_cfg_pkg::sniff_code_lsb +: 4]);
	assign stby_lu  = standby_lookup(sniff_pm,
		r.sniff_reg[rate_cfg_pkg::standby_rate_lsb +: 3]);

	always_comb
	begin
		next_r = r;
		// plain single writes, full byte kept as written
		if (reg_wr_en && reg_addr == rate_cfg_pkg::addr_wake_sample_rate)
			next_r.wake_reg = reg_wr_data;
		if (reg_wr_en && reg_addr == rate_cfg_pkg::addr_sniff_standby)
			next_r.sniff_reg = reg_wr_data;
		if (reg_rd_en)
		begin
			case (reg_addr)
				rate_cfg_pkg::addr_wake_sample_rate: next_r.rd_data = r.wake_reg;
				rate_cfg_pkg::addr_sniff_standby:    next_r.rd_data = r.sniff_reg;
				default:                             next_r.rd_data = 8'h00;
			endcase
		end
		next_r.wake_dhz  = wake_lu[15:0];
		next_r.wake_ok   = wake_lu[16];
		next_r.sniff_dhz = sniff_lu[15:0];
		next_r.sniff_ok  = sniff_lu[16];
		next_r.stby_dhz  = stby_lu;
		next_r.unl       = unlocked;
		case (operating_mode_field)
			rate_cfg_pkg::op_continuous_wake,
			rate_cfg_pkg::op_sniff_wake,
			rate_cfg_pkg::op_trigger:  next_r.active_dhz = wake_lu[15:0];
			rate_cfg_pkg::op_sniff:    next_r.active_dhz = sniff_lu[15:0];
			rate_cfg_pkg::op_standby:  next_r.active_dhz = stby_lu;
			default:                   next_r.active_dhz = 16'h0000;
		endcase
		// continuous wake keeps the sniff circuitry off
		next_r.sniff_on = (operating_mode_field == rate_cfg_pkg::op_sniff) ||
			(operating_mode_field == rate_cfg_pkg::op_sniff_wake);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r            <= '0;
			r.wake_reg   <= rate_cfg_pkg::wake_sample_rate_reset;
			r.sniff_reg  <= rate_cfg_pkg::sniff_standby_rate_reset;
		end
		else
			r <= next_r;
	end

	assign reg_rd_data      = r.rd_data;
	assign wake_rate_dhz    = r.wake_dhz;
	assign wake_rate_ok     = r.wake_ok;
	assign sniff_rate_dhz   = r.sniff_dhz;
	assign sniff_rate_ok    = r.sniff_ok;
	assign standby_rate_dhz = r.stby_dhz;
	assign active_rate_dhz  = r.active_dhz;
	assign sniff_active     = r.sniff_on;
	assign rate15_unlocked  = r.unl;

endmodule : wake_sniff_rate_config

/* src/rate_cfg_pkg.sv */
package rate_cfg_pkg;

	// register addresses on the serial control port
	localparam logic [7:0] addr_mode_ctrl        = 8'h10;
	localparam logic [7:0] addr_wake_sample_rate = 8'h11;
	localparam logic [7:0] addr_sniff_standby    = 8'h12;
	localparam logic [7:0] addr_power_mode       = 8'h1C;
	localparam logic [7:0] addr_trig_shadow      = 8'h29;

	localparam logic [7:0] wake_sample_rate_reset   = 8'h00;
	localparam logic [7:0] sniff_standby_rate_reset = 8'h00;

	// field positions
	localparam int wake_code_lsb     = 0;
	localparam int sniff_code_lsb    = 0;
	localparam int standby_rate_lsb  = 5;
	localparam int wake_pm_lsb       = 0;
	localparam int sniff_pm_lsb      = 4;

	// power mode codes, same values in both fields
	localparam logic [2:0] pm_low_power       = 3'h0;
	localparam logic [2:0] pm_ultra_low_power = 3'h3;
	localparam logic [2:0] pm_precision       = 3'h4;

	// operating_mode_field encodings
	localparam logic [2:0] op_sleep           = 3'h0;
	localparam logic [2:0] op_standby         = 3'h1;
	localparam logic [2:0] op_sniff           = 3'h2;
	localparam logic [2:0] op_continuous_wake = 3'h5;
	localparam logic [2:0] op_sniff_wake      = 3'h6;
	localparam logic [2:0] op_trigger         = 3'h7;

	// rate-15 unlock sequence values
	localparam logic [7:0] unl_point_a   = 8'h10;
	localparam logic [7:0] unl_setup_a   = 8'h03;
	localparam logic [7:0] unl_point_b   = 8'h20;
	localparam logic [7:0] unl_setup_b   = 8'h01;
	localparam logic [7:0] unl_point_v1  = 8'h40;
	localparam logic [7:0] unl_point_v2  = 8'h50;
	localparam logic [7:0] unl_apply     = 8'h0F;
	localparam logic [7:0] unl_v1_ultra  = 8'h52;
	localparam logic [7:0] unl_v1_lp     = 8'h72;
	localparam logic [7:0] unl_v1_prec   = 8'h32;
	localparam logic [7:0] unl_v2_ultra  = 8'h01;
	localparam logic [7:0] unl_v2_lp     = 8'h02;
	localparam logic [7:0] unl_v2_prec   = 8'h12;
	localparam logic [3:0] rate15_code   = 4'hF;

	typedef enum logic [3:0] {
		unl_idle    = 4'b0000,
		unl_pt_a    = 4'b0001,
		unl_set_a   = 4'b0010,
		unl_pt_b    = 4'b0011,
		unl_set_b   = 4'b0100,
		unl_pt_v1   = 4'b0101,
		unl_wr_v1   = 4'b0110,
		unl_pt_v2   = 4'b0111,
		unl_wr_v2   = 4'b1000
	} unlock_state_t;

endpackage : rate_cfg_pkg

/* src/rate15_unlock.sv */
module rate15_unlock
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [2:0] wake_power_mode,
	output logic            unlocked
);

	typedef struct packed {
		rate_cfg_pkg::unlock_state_t state;
		logic                        unlocked;
	} unl_regs_t;

	unl_regs_t r;
	unl_regs_t next_r;

	logic [7:0] value_one;
	logic [7:0] value_two;
	logic       rate_wr;
	logic       shadow_wr;

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		case (wake_power_mode)
			rate_cfg_pkg::pm_ultra_low_power:
			begin
				value_one = rate_cfg_pkg::unl_v1_ultra;
				value_two = rate_cfg_pkg::unl_v2_ultra;
			end
			rate_cfg_pkg::pm_precision:
			begin
				value_one = rate_cfg_pkg::unl_v1_prec;
				value_two = rate_cfg_pkg::unl_v2_prec;
			end
			default:
			begin
				value_one = rate_cfg_pkg::unl_v1_lp;
				value_two = rate_cfg_pkg::unl_v2_lp;
			end
		endcase
	end

	assign rate_wr   = wr_en && (addr == rate_cfg_pkg::addr_wake_sample_rate);
	assign shadow_wr = wr_en && (addr == rate_cfg_pkg::addr_trig_shadow);

	// any off-sequence write to either register restarts the walk
	always_comb
	begin
		next_r = r;
		if (rate_wr || shadow_wr)
		begin
			next_r.state = rate_cfg_pkg::unl_idle;
			case (r.state)
				rate_cfg_pkg::unl_pt_a:
					if (shadow_wr && wr_data == rate_cfg_pkg::unl_setup_a)
						next_r.state = rate_cfg_pkg::unl_set_a;
				rate_cfg_pkg::unl_set_a:
					if (rate_wr && wr_data == rate_cfg_pkg::unl_point_b)
						next_r.state = rate_cfg_pkg::unl_pt_b;
				rate_cfg_pkg::unl_pt_b:
					if (shadow_wr && wr_data == rate_cfg_pkg::unl_setup_b)
						next_r.state = rate_cfg_pkg::unl_set_b;
				rate_cfg_pkg::unl_set_b:
					if (rate_wr && wr_data == rate_cfg_pkg::unl_point_v1)
						next_r.state = rate_cfg_pkg::unl_pt_v1;
				rate_cfg_pkg::unl_pt_v1:
					if (shadow_wr && wr_data == value_one)
						next_r.state = rate_cfg_pkg::unl_wr_v1;
				rate_cfg_pkg::unl_wr_v1:
					if (rate_wr && wr_data == rate_cfg_pkg::unl_point_v2)
						next_r.state = rate_cfg_pkg::unl_pt_v2;
				rate_cfg_pkg::unl_pt_v2:
					if (shadow_wr && wr_data == value_two)
						next_r.state = rate_cfg_pkg::unl_wr_v2;
				rate_cfg_pkg::unl_wr_v2:
					if (rate_wr && wr_data == rate_cfg_pkg::unl_apply)
						next_r.unlocked = 1'b1;
				default:
					next_r.state = rate_cfg_pkg::unl_idle;
			endcase
			// a fresh start pointer is always accepted
			if (rate_wr && wr_data == rate_cfg_pkg::unl_point_a)
				next_r.state = rate_cfg_pkg::unl_pt_a;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r.state    <= rate_cfg_pkg::unl_idle;
			r.unlocked <= 1'b0;
		end
		else
			r <= next_r;
	end

	assign unlocked = r.unlocked;

endmodule : rate15_unlock

/* dv/wsr_properties.sv */
module wsr_properties
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        reg_wr_en,
	input wire logic        reg_rd_en,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wr_data,
	input wire logic [7:0]  power_mode_reg,
	input wire logic [2:0]  operating_mode_field,
	input wire logic [7:0]  reg_rd_data,
	input wire logic [15:0] wake_rate_dhz,
	input wire logic        wake_rate_ok,
	input wire logic [15:0] sniff_rate_dhz,
	input wire logic        sniff_rate_ok,
	input wire logic [15:0] standby_rate_dhz,
	input wire logic [15:0] active_rate_dhz,
	input wire logic        sniff_active,
	input wire logic        rate15_unlocked
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire w11 = reg_wr_en && reg_addr == 8'h11;
	wire w12 = reg_wr_en && reg_addr == 8'h12;
	////////////////////////////////////////////////////////////////////////////////
	unmapped_read_a: assert property (reg_rd_en && reg_addr != 8'h11 && reg_addr != 8'h12
		|=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
	read_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
		else $error("read data moved without a read");
	write_readback_a: assert property (w11 ##1 !reg_wr_en ##1 reg_rd_en && !reg_wr_en
		&& reg_addr == 8'h11 |=> reg_rd_data == $past(reg_wr_data, 3)) else $error("readback");
	wake_no_sniff_a: assert property (operating_mode_field == 3'h5 |=> !sniff_active)
		else $error("sniff active in continuous wake");
	wake_lookup_a: assert property (w11 && reg_wr_data == 8'h07 && power_mode_reg[2:0] == 3'h3
		##1 (!w11 && power_mode_reg[2:0] == 3'h3) [*2] |-> wake_rate_dhz == 16'h01f4 && wake_rate_ok)
		else $error("wake rate lookup");
	standby_lookup_a: assert property (w12 && reg_wr_data[7:5] == 3'h7
		&& power_mode_reg[6:4] == 3'h3 ##1 (!w12 && power_mode_reg[6:4] == 3'h3) [*2]
		|-> standby_rate_dhz == 16'h0708) else $error("standby rate lookup");
	unlock_sticky_a: assert property (rate15_unlocked |=> rate15_unlocked)
		else $error("unlock flag dropped");
	unlock_cause_a: assert property ($rose(rate15_unlocked)
		|-> $past(w11, 2) && $past(reg_wr_data, 2) == 8'h0f) else $error("unlock without apply");
	cover property (w11 && reg_wr_data == 8'h0f);
	cover property ($rose(rate15_unlocked));
	cover property (operating_mode_field == 3'h2 ##1 sniff_active);
endmodule : wsr_properties

bind wake_sniff_rate_config wsr_properties props_u (.*);

/* dv/host_model.sv */
module host_model
(
	input  wire logic clk,
	output logic      wr_en,
	output logic      rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_en = w;
		rd_en = !w;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		// released lines never keep the last value
		addr = ~a;
		wdata = ~d;
	endtask : xfer
	// bad spoils value one so the tracker must restart
	task automatic unlock(input logic [2:0] pm, input logic bad);
		logic [7:0] v1;
		logic [7:0] v2;
		v1 = pm == 3'h3 ? 8'h52 : pm == 3'h4 ? 8'h32 : 8'h72;
		v2 = pm == 3'h3 ? 8'h01 : pm == 3'h4 ? 8'h12 : 8'h02;
		xfer(1'b1, 8'h10, 8'h01);
		xfer(1'b1, 8'h15, 8'h04);
		xfer(1'b1, 8'h16, 8'h5d);
		xfer(1'b1, 8'h1c, {5'h00, pm});
		xfer(1'b1, 8'h11, 8'h10);
		xfer(1'b1, 8'h29, 8'h03);
		xfer(1'b1, 8'h11, 8'h20);
		xfer(1'b1, 8'h29, 8'h01);
		xfer(1'b1, 8'h11, 8'h40);
		xfer(1'b1, 8'h29, v1 ^ {7'h00, bad});
		xfer(1'b1, 8'h11, 8'h50);
		xfer(1'b1, 8'h29, v2);
		xfer(1'b1, 8'h11, 8'h0f);
		xfer(1'b1, 8'h10, 8'h05);
	endtask : unlock
endmodule : host_model

/* dv/test_wake_sniff_rate_config.sv */
module test_wake_sniff_rate_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	logic [7:0]       pm = 8'h00;
	logic [2:0]       op = 3'h1;
	logic [31:0]      rnd = 32'h0000_e4d1;
	wire logic        wr_en, rd_en, wk_ok, sn_ok, sn_act, unl;
	wire logic [7:0]  addr, wdata, rd_data;
	wire logic [15:0] wk, sn, sb, act;
	int               n_errors = 0;
	int               cmp_count = 0;
	int               m11 = 0;
	int               m12 = 0;
	int               munl = 0;
	int               pms[$] = '{3, 0, 4, 1};
	// rates in tenths of Hz, zero where unsupported
	localparam int wt[3][16] = '{'{0,0,0,0,0,0,250,500,1000,1900,3800,7500,11000,0,0,13000},
		'{0,0,0,0,0,140,280,540,1050,2100,4000,6000,0,0,0,7500},
		'{0,0,0,0,0,140,280,550,800,0,0,0,0,0,0,1000}};
	localparam int st[3][16] = '{'{60,4,8,15,60,130,250,500,1000,1900,3800,7500,11000,0,0,0},
		'{70,4,8,15,70,140,280,540,1050,2100,4000,6000,0,0,0,0},
		'{70,2,4,9,70,140,280,550,800,0,0,0,0,0,0,0}};
	localparam int bt[3][8] = '{'{10,30,50,100,230,450,900,1800},
		'{5,10,30,60,120,240,480,1000}, '{1,2,4,8,15,30,50,100}};
	always #2 clk = ~clk;
	host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
	wake_sniff_rate_config dut_u
	(
		.clk(clk), .reset_n(reset_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
		.reg_wr_data(wdata), .power_mode_reg(pm), .operating_mode_field(op),
		.reg_rd_data(rd_data), .wake_rate_dhz(wk), .wake_rate_ok(wk_ok),
		.sniff_rate_dhz(sn), .sniff_rate_ok(sn_ok), .standby_rate_dhz(sb),
		.active_rate_dhz(act), .sniff_active(sn_act), .rate15_unlocked(unl)
	);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic int col(input logic [2:0] p);
		return p == 3'h3 ? 0 : p == 3'h0 ? 1 : p == 3'h4 ? 2 : 3;
	endfunction : col
	task automatic chk(input string n, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.xfer(1'b1, a, d);
		m11 = a == 8'h11 ? d : m11;
		m12 = a == 8'h12 ? d : m12;
	endtask : wr
	task automatic rd_chk(input logic [7:0] a);
		host_u.xfer(1'b0, a, 8'h00);
		chk("reg_rd_data", a == 8'h11 ? m11 : a == 8'h12 ? m12 : 0, rd_data);
	endtask : rd_chk
	task automatic chk_rates();
		int cw;
		int cs;
		int w;
		int s;
		int b;
		repeat (2) @(posedge clk);
		#1;
		cw = col(pm[2:0]);
		cs = col(pm[6:4]);
		w = (cw > 2 || (m11 % 16 == 15 && munl == 0)) ? 0 : wt[cw][m11 % 16];
		s = cs > 2 ? 0 : st[cs][m12 % 16];
		b = cs > 2 ? 0 : bt[cs][m12 / 32];
		chk("wake_rate_dhz", w, wk);
		chk("wake_rate_ok", w != 0, wk_ok);
		chk("sniff_rate_dhz", s, sn);
		chk("sniff_rate_ok", s != 0, sn_ok);
		chk("standby_rate_dhz", b, sb);
		chk("active_rate_dhz", op >= 3'h5 ? w : op == 3'h2 ? s : op == 3'h1 ? b : 0, act);
		chk("sniff_active", op == 3'h2 || op == 3'h6, sn_act);
	endtask : chk_rates
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		n_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		reset_n = 1'b1;
		rd_chk(8'h11);
		rd_chk(8'h12);
		rd_chk(8'h13);
		// wake and sniff columns differ so a swapped field shows up
		foreach (pms[i])
		begin
			pm = {1'b0, 3'(pms[(i + 1) % 4]), 1'b0, 3'(pms[i])};
			for (int c = 0; c < 16; c++)
			begin
				rnd = lfsr(rnd);
				wr(8'h11, 8'(c));
				rd_chk(8'h11);
				wr(8'h12, {3'(c), 1'b0, rnd[3:0]});
				rd_chk(8'h12);
				chk_rates();
			end
		end
		for (int o = 0; o < 8; o++)
		begin
			op = 3'(o);
			chk_rates();
		end
		op = 3'h1;
		pm = 8'h33;
		host_u.unlock(3'h3, 1'b1);
		m11 = 15;
		chk_rates();
		chk("rate15_unlocked", 16'h0000, unl);
		host_u.unlock(3'h3, 1'b0);
		munl = 1;
		op = 3'h5;
		chk_rates();
		chk("rate15_unlocked", 16'h0001, unl);
		foreach (pms[i])
		begin
			pm = {1'b0, 3'(pms[i]), 1'b0, 3'(pms[i])};
			chk_rates();
		end
		rd_chk(8'h29);
		report_and_stop();
	end
endmodule : test_wake_sniff_rate_config
